/* shared/shcp_map.svh */
`ifndef SHCP_MAP_SVH
`define SHCP_MAP_SVH
// command opcodes, upper nibble of the first byte
`define SHCP_OP_WAKE_FAST      4'h0
`define SHCP_OP_WAKE_SOFT      4'h1
`define SHCP_OP_SLEEP_FAST     4'h2
`define SHCP_OP_SLEEP_SOFT     4'h3
`define SHCP_OP_PLAY           4'h4
`define SHCP_OP_START          4'h5
`define SHCP_OP_PHRASE_SELECT  4'h6
`define SHCP_OP_STOP           4'h7
`define SHCP_OP_SILENCE_INSERT 4'h8
`define SHCP_OP_LOOP_SET       4'h9
`define SHCP_OP_LOOP_CLEAR     4'ha
`define SHCP_OP_GAIN_SET       4'hb
`define SHCP_OP_PAN            4'hc
// field positions
`define SHCP_OP_HI   7
`define SHCP_OP_LO   4
`define SHCP_MASK_HI 3
`define SHCP_MASK_LO 0
`define SHCP_LEVEL_HI 4
// serial-mode roles of the shared data lines
`define SHCP_PIN_SDI  7
`define SHCP_PIN_SCK  6
`define SHCP_PIN_SSEL 4
// status byte layout
`define SHCP_STAT_BUSY_LO 4
`define SHCP_STAT_READY_LO 0
// processing time of one command in clk cycles
`define SHCP_PROC_CYCLES 4'h8
`define SHCP_BIT_LAST    3'h7
`endif

/* shared/shcp_pkg.sv */
package shcp_pkg;
  typedef enum logic [1:0] {
    SHCP_IDLE  = 2'b00,
    SHCP_ARG1  = 2'b01,
    SHCP_ARG2  = 2'b10
  } shcp_state_type;
endpackage

/* hdl/shcp_sync.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// two-flop synchroniser for one pin level
// ------------------------------------------------------------
module shcp_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pinIn,
  output logic      pinSync
);
  logic stage1;
  logic next_stage1;
  logic next_pinSync;

  // first flop feeds only the second
  always_comb begin
    next_stage1  = reset_n ? pinIn : 1'b1;
    next_pinSync = reset_n ? stage1 : 1'b1;
  end

  always_ff @(posedge clk) begin
    stage1  <= next_stage1;
    pinSync <= next_pinSync;
  end
endmodule

/* hdl/shcp_host_port.sv */
`timescale 1ns/1ns
`include "shcp_map.svh"
module shcp_host_port
  import shcp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       chipSelect_n,
  input  wire logic       write_n,
  input  wire logic       read_n,
  input  wire logic       serialMode,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic            dataOe_n,
  output logic            serialOut,
  output logic      [3:0] chanStatus,
  input  wire logic [3:0] playDone,
  output logic            poweredUp,
  output logic            softPower,
  output logic      [3:0] playing,
  output logic      [3:0] loopMode,
  output logic      [3:0] playStrobe,
  output logic      [7:0] phrase0,
  output logic      [7:0] phrase1,
  output logic      [7:0] phrase2,
  output logic      [7:0] phrase3,
  output logic      [3:0] silenceStrobe,
  output logic      [7:0] silenceLength,
  output logic      [4:0] volume0,
  output logic      [4:0] volume1,
  output logic      [4:0] volume2,
  output logic      [4:0] volume3,
  output logic      [4:0] panLeft,
  output logic      [4:0] panRight,
  output logic      [3:0] panStrobe
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [11:0] rawPins;
  logic [11:0] syncPins;
  assign rawPins = {chipSelect_n, write_n, read_n, serialMode, dataIn};

  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_sync
      shcp_sync u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .pinIn   (rawPins[gi]),
        .pinSync (syncPins[gi])
      );
    end
  endgenerate

  logic       csN, wrN, rdN, serSel;
  logic [7:0] pinData;
  assign {csN, wrN, rdN, serSel, pinData} = syncPins;
  // shared pins in serial mode: D7 data in, D6 shift clock, D4 status select
  logic sckLvl, sdiLvl, statSel;
  assign sdiLvl  = pinData[`SHCP_PIN_SDI];
  assign sckLvl  = pinData[`SHCP_PIN_SCK];
  assign statSel = pinData[`SHCP_PIN_SSEL];

  // ------------------------------------------------------------
  // edge detection and serial shift
  // ------------------------------------------------------------
  logic       csPrev, wrPrev, sckPrev;
  logic       edgeFall;                 // 1: capture on falling shift edge
  logic [7:0] shiftIn;
  logic [7:0] shiftOut;
  logic       next_edgeFall;
  logic [7:0] next_shiftIn, next_shiftOut;
  logic       csFall, wrRise, sckRise, sckFall, capEdge, rdActive;
  logic       byteValid;
  logic [7:0] byteIn;
  logic [7:0] statusByte;

  assign csFall   = csPrev & ~csN;
  assign wrRise   = ~csN & ~wrPrev & wrN;
  assign sckRise  = ~sckPrev & sckLvl;
  assign sckFall  = sckPrev & ~sckLvl;
  assign capEdge  = edgeFall ? sckFall : sckRise;
  assign rdActive = ~csN & ~rdN;
  assign byteValid = wrRise;
  assign byteIn    = serSel ? shiftIn : pinData;

  // edge choice latched at select fall; shift registers move on chosen edge
  always_comb begin
    next_edgeFall = csFall ? sckLvl : edgeFall;
    next_shiftIn  = shiftIn;
    next_shiftOut = shiftOut;
    if (serSel && !csN && !wrN && capEdge && !csFall) begin
      next_shiftIn = {shiftIn[6:0], sdiLvl};
    end
    if (csFall || !rdActive) begin
      next_shiftOut = statusByte;                                // reload per read frame
    end else if (serSel && capEdge) begin
      next_shiftOut = {shiftOut[6:0], 1'b1};
    end
    if (!reset_n) begin
      next_edgeFall = 1'b0;
      next_shiftIn  = 8'h00;
      next_shiftOut = 8'hff;
    end
  end

  always_ff @(posedge clk) begin
    csPrev   <= reset_n ? csN : 1'b1;
    wrPrev   <= reset_n ? wrN : 1'b1;
    sckPrev  <= reset_n ? sckLvl : 1'b1;                         // matches sync reset, no false edge
    edgeFall <= next_edgeFall;
    shiftIn  <= next_shiftIn;
    shiftOut <= next_shiftOut;
  end

  // ------------------------------------------------------------
  // command decoder
  // ------------------------------------------------------------
  shcp_state_type state, next_state;
  logic [3:0] op, next_op;
  logic [3:0] mask, next_mask;
  logic [3:0] procCount, next_procCount;
  logic       next_poweredUp, next_softPower;
  logic [3:0] next_playing, next_loopMode, next_playStrobe;
  logic [3:0] pending, next_pending;                             // phrase stored, not started
  logic [7:0] next_phrase [4];
  logic [4:0] next_volume [4];
  logic [3:0] next_silenceStrobe, next_panStrobe;
  logic [7:0] next_silenceLength;
  logic [4:0] next_panLeft, next_panRight;
  logic [7:0] phraseArr [4];
  logic [4:0] levelArr [4];
  logic [3:0] cmdMask;
  logic [3:0] cmdOp;
  assign cmdOp   = byteIn[`SHCP_OP_HI:`SHCP_OP_LO];
  assign cmdMask = byteIn[`SHCP_MASK_HI:`SHCP_MASK_LO];
  assign phrase0 = phraseArr[0];
  assign phrase1 = phraseArr[1];
  assign phrase2 = phraseArr[2];
  assign phrase3 = phraseArr[3];
  assign volume0 = levelArr[0];
  assign volume1 = levelArr[1];
  assign volume2 = levelArr[2];
  assign volume3 = levelArr[3];

  // decode first bytes and gather argument bytes
  always_comb begin
    next_state         = state;
    next_op            = op;
    next_mask          = mask;
    next_procCount     = (procCount != 4'h0) ? procCount - 4'h1 : 4'h0;
    next_poweredUp     = poweredUp;
    next_softPower     = softPower;
    next_playing       = playing & ~playDone & ~playStrobe | playStrobe;
    next_loopMode      = loopMode & (playing & ~playDone);
    next_playStrobe    = 4'h0;
    next_pending       = pending;
    next_silenceStrobe = 4'h0;
    next_panStrobe     = 4'h0;
    next_silenceLength = silenceLength;
    next_panLeft       = panLeft;
    next_panRight      = panRight;
    for (int i = 0; i < 4; i++) begin
      next_phrase[i] = phraseArr[i];
      next_volume[i] = levelArr[i];
    end
    if (byteValid) begin
      next_procCount = `SHCP_PROC_CYCLES;
      unique case (state)
        SHCP_IDLE: begin
          next_op   = cmdOp;
          next_mask = cmdMask;
          case (cmdOp)
            `SHCP_OP_WAKE_FAST, `SHCP_OP_WAKE_SOFT: begin
              next_poweredUp = 1'b1;
              next_softPower = cmdOp[0];
            end
            `SHCP_OP_SLEEP_FAST, `SHCP_OP_SLEEP_SOFT: begin
              next_poweredUp = 1'b0;
              next_softPower = cmdOp[0];
            end
            `SHCP_OP_START: begin
              next_playStrobe = cmdMask & pending;
              next_pending    = pending & ~cmdMask;
            end
            `SHCP_OP_STOP: begin
              next_playing  = next_playing & ~cmdMask;
              next_loopMode = next_loopMode & ~cmdMask;
            end
            `SHCP_OP_LOOP_SET: begin
              next_loopMode = next_loopMode | (cmdMask & playing);
            end
            `SHCP_OP_LOOP_CLEAR: begin
              next_loopMode = next_loopMode & ~cmdMask;
            end
            `SHCP_OP_PLAY, `SHCP_OP_PHRASE_SELECT, `SHCP_OP_SILENCE_INSERT,
            `SHCP_OP_GAIN_SET, `SHCP_OP_PAN: begin
              next_state = SHCP_ARG1;
            end
            default: next_state = SHCP_IDLE;
          endcase
        end
        SHCP_ARG1: begin
          next_state = SHCP_IDLE;
          case (op)
            `SHCP_OP_PLAY, `SHCP_OP_PHRASE_SELECT: begin
              for (int i = 0; i < 4; i++) begin
                if (mask[i]) begin
                  next_phrase[i] = byteIn;
                end
              end
              if (op == `SHCP_OP_PLAY) begin
                next_playStrobe = mask;
              end else begin
                next_pending = pending | mask;
              end
            end
            `SHCP_OP_SILENCE_INSERT: begin
              next_silenceLength = byteIn;
              next_silenceStrobe = mask;
            end
            `SHCP_OP_GAIN_SET: begin
              for (int i = 0; i < 4; i++) begin
                if (mask[i]) begin
                  next_volume[i] = byteIn[`SHCP_LEVEL_HI:0];
                end
              end
            end
            default: begin
              next_panLeft = byteIn[`SHCP_LEVEL_HI:0];
              next_state   = SHCP_ARG2;
            end
          endcase
        end
        SHCP_ARG2: begin
          next_panRight  = byteIn[`SHCP_LEVEL_HI:0];
          next_panStrobe = mask;
          next_state     = SHCP_IDLE;
        end
        default: next_state = SHCP_IDLE;
      endcase
    end
    if (!reset_n) begin
      next_state         = SHCP_IDLE;
      next_op            = 4'h0;
      next_mask          = 4'h0;
      next_procCount     = 4'h0;
      next_poweredUp     = 1'b0;
      next_softPower     = 1'b0;
      next_playing       = 4'h0;
      next_loopMode      = 4'h0;
      next_playStrobe    = 4'h0;
      next_pending       = 4'h0;
      next_silenceStrobe = 4'h0;
      next_panStrobe     = 4'h0;
      next_silenceLength = 8'h00;
      next_panLeft       = 5'h00;
      next_panRight      = 5'h00;
      for (int i = 0; i < 4; i++) begin
        next_phrase[i] = 8'h00;
        next_volume[i] = 5'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    state         <= next_state;
    op            <= next_op;
    mask          <= next_mask;
    procCount     <= next_procCount;
    poweredUp     <= next_poweredUp;
    softPower     <= next_softPower;
    playing       <= next_playing;
    loopMode      <= next_loopMode;
    playStrobe    <= next_playStrobe;
    pending       <= next_pending;
    silenceStrobe <= next_silenceStrobe;
    panStrobe     <= next_panStrobe;
    silenceLength <= next_silenceLength;
    panLeft       <= next_panLeft;
    panRight      <= next_panRight;
    for (int i = 0; i < 4; i++) begin
      phraseArr[i] <= next_phrase[i];
      levelArr[i]  <= next_volume[i];
    end
  end

  // ------------------------------------------------------------
  // status and pin outputs
  // ------------------------------------------------------------
  logic       busyCmd;
  logic [3:0] busyN, readyN;
  logic [7:0] next_dataOut;
  logic       next_dataOe_n, next_serialOut;
  logic [3:0] next_chanStatus;
  assign busyCmd    = (procCount != 4'h0);
  assign busyN      = busyCmd ? 4'h0 : ~playing;
  assign readyN     = busyCmd ? 4'h0 : ~pending;
  assign statusByte = {busyN, readyN};

  // enable is low while driving; parallel reads only
  always_comb begin
    next_dataOut    = statusByte;
    next_dataOe_n   = ~(rdActive & ~serSel);
    next_serialOut  = shiftOut[7];
    next_chanStatus = statSel ? busyN : readyN;
    if (!reset_n) begin
      next_dataOut    = 8'h00;
      next_dataOe_n   = 1'b1;
      next_serialOut  = 1'b1;
      next_chanStatus = 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    dataOut    <= next_dataOut;
    dataOe_n   <= next_dataOe_n;
    serialOut  <= next_serialOut;
    chanStatus <= next_chanStatus;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence wr_seen;
    byteValid;
  endsequence
  sequence busy_hold;
    busyCmd [*7];
  endsequence

  busy_after_cmd_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_seen |=> busy_hold ##1 busyCmd ##1 !busyCmd) else $error("busy time wrong");
  oe_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    csN |=> dataOe_n) else $error("data driven without select");
  status_layout_a: assert property (@(posedge clk) disable iff (!reset_n)
    !busyCmd |=> dataOut == {~$past(playing), ~$past(pending)}) else $error("status layout");
  ready_low_a: assert property (@(posedge clk) disable iff (!reset_n)
    busyCmd |=> dataOut == 8'h00) else $error("flags high during command");
  edge_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
    csFall |=> edgeFall == $past(sckLvl)) else $error("edge choice not latched");
  stop_clears_a: assert property (@(posedge clk) disable iff (!reset_n)
    byteValid && state == SHCP_IDLE && cmdOp == `SHCP_OP_STOP
    |=> (playing & $past(cmdMask)) == 4'h0 && (loopMode & $past(cmdMask)) == 4'h0)
    else $error("stop left channel running");
  wake_a: assert property (@(posedge clk) disable iff (!reset_n)
    byteValid && state == SHCP_IDLE && cmdOp == `SHCP_OP_WAKE_FAST |=> poweredUp)
    else $error("wake ignored");
  sleep_a: assert property (@(posedge clk) disable iff (!reset_n)
    byteValid && state == SHCP_IDLE && cmdOp == `SHCP_OP_SLEEP_SOFT
    |=> !poweredUp && softPower) else $error("sleep ignored");
  pan_two_a: assert property (@(posedge clk) disable iff (!reset_n)
    panStrobe != 4'h0 |-> $past(state) == SHCP_ARG2) else $error("pan strobe early");
endmodule

/* bench/shcp_host_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// host microcontroller model, parallel and serial port access
// ------------------------------------------------------------
module shcp_host_model (
  input  wire logic       clk,
  input  wire logic       serialOut,
  input  wire logic       dataOe_n,
  input  wire logic [7:0] dataIn,
  output logic            chipSelect_n,
  output logic            write_n,
  output logic            read_n,
  output logic      [7:0] hostBus
);
  // idle pins: nothing selected
  initial begin
    chipSelect_n = 1'b1;
    write_n      = 1'b1;
    read_n       = 1'b1;
    hostBus      = 8'h00;
  end

  // byte strobe; csOff leaves select high so the device must ignore it
  task automatic par_write(input logic [7:0] b, input logic csOff);
    @(negedge clk);
    hostBus      = b;
    chipSelect_n = csOff;
    @(negedge clk);
    write_n = 1'b0;
    repeat (4) @(negedge clk);
    write_n = 1'b1;
    repeat (3) @(negedge clk);
    chipSelect_n = 1'b1;
    hostBus      = ~hostBus;  // released lines must not keep the old byte
  endtask

  // select and read strobe held, byte taken from the resolved pins
  task automatic par_read(output logic [7:0] b, output logic oe_n);
    @(negedge clk);
    chipSelect_n = 1'b0;
    read_n       = 1'b0;
    repeat (6) @(negedge clk);
    b            = dataIn;
    oe_n         = dataOe_n;
    chipSelect_n = 1'b1;
    read_n       = 1'b1;
  endtask

  // shift clock parked at its idle level while select falls
  task automatic ser_open(input logic idle, input logic sel, input logic rd);
    @(negedge clk);
    {hostBus[6], hostBus[4]} = {idle, sel};
    repeat (4) @(negedge clk);
    read_n  = ~rd;
    write_n = rd;
    @(negedge clk);
    chipSelect_n = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // one bit: data with the clock at idle, then the active edge; the output is
  // read just before that edge, since the device moves it on the same edge
  task automatic ser_bit(input logic idle, input logic d, output logic q);
    hostBus[7:6] = {d, idle};
    repeat (8) @(negedge clk);
    q          = serialOut;
    hostBus[6] = ~idle;
    repeat (8) @(negedge clk);
  endtask

  // one byte per frame, msb first, executed at the strobe release
  task automatic ser_write(input logic idle, input logic [7:0] b);
    logic q;
    ser_open(idle, 1'b0, 1'b0);
    for (int i = 7; i >= 0; i--) ser_bit(idle, b[i], q);
    hostBus[6] = idle;  // park the clock before the strobe rises
    @(negedge clk);
    write_n = 1'b1;
    repeat (4) @(negedge clk);
    chipSelect_n = 1'b1;
    hostBus[7]   = ~hostBus[7];
  endtask

  // status shifted out, first bit seen is bit 7
  task automatic ser_read(input logic idle, output logic [7:0] b, output logic oe);
    ser_open(idle, idle, 1'b1);
    for (int i = 7; i >= 0; i--) ser_bit(idle, ~hostBus[7], b[i]);
    oe         = dataOe_n;
    hostBus[6] = idle;
    @(negedge clk);
    read_n       = 1'b1;
    chipSelect_n = 1'b1;
  endtask
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// command port testbench
// ------------------------------------------------------------
module testbench;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       serialMode = 1'b0;
  logic [3:0] playDone = 4'h0;
  logic       chipSelect_n, write_n, read_n, dataOe_n, serialOut, poweredUp, softPower;
  logic [7:0] hostBus, dataOut, dataIn, phrase0, phrase1, phrase2, phrase3, silenceLength;
  logic [3:0] chanStatus, playing, loopMode, playStrobe, silenceStrobe, panStrobe;
  logic [4:0] volume0, volume1, volume2, volume3, panLeft, panRight;
  logic [3:0] playSeen = 4'h0;
  logic [3:0] silSeen = 4'h0;
  logic [3:0] panSeen = 4'h0;
  logic       seenClr = 1'b0;
  logic [7:0] pwrExp [4] = '{8'h02, 8'h03, 8'h00, 8'h01};
  logic [7:0] rb;
  logic       oe;
  int         n_fail = 0;
  int         cmp_count = 0;

  always #5 clk = ~clk;
  // the device wins the data pins only while it enables them
  assign dataIn = dataOe_n ? hostBus : dataOut;
  // one-cycle strobes are collected so none slips between samples
  always @(posedge clk) begin
    playSeen <= seenClr ? 4'h0 : playSeen | playStrobe;
    silSeen  <= seenClr ? 4'h0 : silSeen | silenceStrobe;
    panSeen  <= seenClr ? 4'h0 : panSeen | panStrobe;
  end

  shcp_host_port i_shcp_host_port (.clk(clk), .reset_n(reset_n),
    .chipSelect_n(chipSelect_n), .write_n(write_n), .read_n(read_n),
    .serialMode(serialMode), .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n),
    .serialOut(serialOut), .chanStatus(chanStatus), .playDone(playDone),
    .poweredUp(poweredUp), .softPower(softPower), .playing(playing), .loopMode(loopMode),
    .playStrobe(playStrobe), .phrase0(phrase0), .phrase1(phrase1), .phrase2(phrase2),
    .phrase3(phrase3), .silenceStrobe(silenceStrobe), .silenceLength(silenceLength),
    .volume0(volume0), .volume1(volume1), .volume2(volume2), .volume3(volume3),
    .panLeft(panLeft), .panRight(panRight), .panStrobe(panStrobe));
  shcp_host_model i_shcp_host_model (.clk(clk), .serialOut(serialOut),
    .dataOe_n(dataOe_n), .dataIn(dataIn), .chipSelect_n(chipSelect_n),
    .write_n(write_n), .read_n(read_n), .hostBus(hostBus));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // parallel write, then room for the processing time to run out
  task automatic cmd(input logic [7:0] b);
    @(negedge clk);
    seenClr = 1'b1;
    @(negedge clk);
    seenClr = 1'b0;
    i_shcp_host_model.par_write(b, 1'b0);
    repeat (16) @(negedge clk);
  endtask
  task automatic stat(input logic [7:0] exp);
    i_shcp_host_model.par_read(rb, oe);
    chk(rb, exp);
    chk({7'h0, oe}, 8'h00);
    repeat (8) @(negedge clk);
    chk({7'h0, dataOe_n}, 8'h01);
  endtask
  task automatic results;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    stat(8'hff);
    for (int i = 0; i < 4; i++) begin
      cmd(8'(i) << 4);
      chk({6'h0, poweredUp, softPower}, pwrExp[i]);
    end
    i_shcp_host_model.par_write(8'h00, 1'b1);
    repeat (16) @(negedge clk);
    chk({7'h0, poweredUp}, 8'h00);
    cmd(8'h00);
    cmd(8'h63);
    cmd(8'h5a);
    chk(phrase0, 8'h5a);
    chk(phrase2, 8'h00);
    chk(phrase1, 8'h5a);
    stat(8'hfc);
    cmd(8'h51);
    chk({playSeen, playing}, 8'h11);
    stat(8'hed);
    // flags must drop while a command is still being processed
    i_shcp_host_model.par_write(8'h93, 1'b0);
    repeat (3) @(negedge clk);
    chk(dataOut, 8'h00);
    repeat (16) @(negedge clk);
    chk({4'h0, loopMode}, 8'h01);
    cmd(8'ha1);
    chk({4'h0, loopMode}, 8'h00);
    cmd(8'h91);
    cmd(8'h71);
    chk({playing, loopMode}, 8'h00);
    stat(8'hfd);
    cmd(8'h48);
    cmd(8'h33);
    chk(phrase3, 8'h33);
    chk({playSeen, playing}, 8'h88);
    stat(8'h7d);
    playDone = 4'h8;
    @(negedge clk);
    playDone = 4'h0;
    repeat (4) @(negedge clk);
    stat(8'hfd);
    cmd(8'h82);
    cmd(8'h40);
    chk({silSeen, 4'h0}, 8'h20);
    chk(silenceLength, 8'h40);
    cmd(8'hb5);
    cmd(8'hff);
    chk({volume2[3:0], volume1[3:0]}, 8'hf0);
    chk({3'h0, volume0}, 8'h1f);
    chk({3'h0, volume3}, 8'h00);
    cmd(8'hc4);
    cmd(8'h0a);
    cmd(8'h15);
    chk({3'h0, panLeft}, 8'h0a);
    chk({3'h0, panRight}, 8'h15);
    chk({4'h0, panSeen}, 8'h04);
    cmd(8'hd1);
    cmd(8'he3);
    cmd(8'hf1);
    chk({playing, loopMode}, 8'h00);
    chk({3'h0, volume0}, 8'h1f);
    stat(8'hfd);
    // serial interface, both capture edges
    serialMode = 1'b1;
    repeat (8) @(negedge clk);
    i_shcp_host_model.ser_write(1'b0, 8'h6c);
    i_shcp_host_model.ser_write(1'b0, 8'h81);
    repeat (16) @(negedge clk);
    chk(phrase3, 8'h81);
    i_shcp_host_model.ser_write(1'b1, 8'hb2);
    i_shcp_host_model.ser_write(1'b1, 8'h07);
    repeat (16) @(negedge clk);
    chk({3'h0, volume1}, 8'h07);
    for (int i = 0; i < 2; i++) begin
      i_shcp_host_model.ser_read(i[0], rb, oe);
      chk(rb, 8'hf1);
      chk({7'h0, oe}, 8'h01);
      repeat (6) @(negedge clk);
      chk({4'h0, chanStatus}, i[0] ? 8'h0f : 8'h01);
    end
    results;
  end

  // hang guard, far beyond the expected run length
  initial begin
    #500000;
    n_fail++;
    $display("Error %0t: timeout", $time);
    results;
  end
endmodule
